// ===== src/rxe_pkg.sv
// Constants shared by the receiver error, interrupt and audio serial port logic.
// Assumes an 8-bit register port at 25 MHz and a frame-rate timing from the serial port.
// What this block does
// - Flag tape start on category plus start ID
// - Suppress bit blocks repeats within 3840 frames
// - Strapped: pins show unlock|parity and auto|non-audio
// - Strapped: error pin held 1024 frames after clearing
// - Strapped: validity pin low on unlock or parity
// - Register mode: pins OR unmasked nine events
// - Register mode: error pin hold, selectable length
// - Register mode: stream pin drops immediately
// - Live status bits never latch
// - Change and tape flags clear on register read
// - Unlock reinitialises stored buffers, pins follow ORs
// - Serial data MSB first, two's complement
// - Data changes on falling, aux sampled rising
// - Master 64fs bit clock; partner clocks slave formats
// - Format select picks justification and frame polarity
// - Short words drop surplus low bits
// - Errored sub-frame repeats last good one
// - Unlocked serial output sends zeros in mode 0
// - Aux input routed in modes 1, 3, unlocked 2
// - Recovery PLL off: both interrupt pins low
// - Auto flag is non-PCM OR detect_a

package rxe_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [4:0] ADDR_CLK = 5'h00;
  localparam logic [4:0] ADDR_FMT = 5'h01;
  localparam logic [4:0] ADDR_IOC1 = 5'h03;
  localparam logic [4:0] ADDR_MASK0 = 5'h04;
  localparam logic [4:0] ADDR_MASK1 = 5'h05;
  localparam logic [4:0] ADDR_TAPE = 5'h06;
  localparam logic [4:0] ADDR_STAT0 = 5'h07;
  localparam logic [4:0] ADDR_STAT1 = 5'h08;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CM_LSB = 4;
  localparam int DIF_LSB = 4;
  localparam int EFH_LSB = 6;
  localparam int SUP_BIT = 4;
  localparam int MDAT1_BIT = 1;
  localparam int MDAT0_BIT = 0;
  localparam int S1_DAT_BIT = 2;
  localparam int S1_DTS_BIT = 1;
  localparam int S1_NONPCM_DETECT_BIT = 0;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [1:0] CM_RST = 2'h0;
  localparam logic [2:0] DIF_RST = 3'h2;
  localparam logic [1:0] EFH_RST = 2'h1;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [2:0] TAPE_CTL_RST = 3'h0;

  // ----------------------------------------------------------------------
  // Counts of frames and clock cycles
  // ----------------------------------------------------------------------
  localparam logic [12:0] HOLD_FRAMES_0 = 13'h0200;
  localparam logic [12:0] HOLD_FRAMES_1 = 13'h0400;
  localparam logic [12:0] HOLD_FRAMES_2 = 13'h0800;
  localparam logic [12:0] HOLD_FRAMES_3 = 13'h1000;
  localparam logic [11:0] TAPE_GAP_FRAMES = 12'hF00;
  localparam logic [3:0] BCLK_HALF_CYCLES = 4'h6;
  localparam logic [5:0] SLOT_LAST_BIT = 6'h1F;

  // Clock operation modes and output formats
  localparam logic [1:0] CM_PLL_OFF = 2'h1;
  localparam logic [1:0] CM_AUX_ALWAYS = 2'h3;
  localparam logic [1:0] CM_AUX_UNLOCK = 2'h2;
  localparam logic [2:0] FMT_RJ16 = 3'h0;
  localparam logic [2:0] FMT_RJ18 = 3'h1;
  localparam logic [2:0] FMT_RJ20 = 3'h2;
  localparam logic [2:0] FMT_RJ24 = 3'h3;
  localparam logic [2:0] FMT_LJ = 3'h4;
  localparam logic [2:0] FMT_I2S = 3'h5;
  localparam logic [2:0] FMT_SLV_LJ = 3'h6;
  localparam logic [2:0] FMT_SLV_I2S = 3'h7;

endpackage : rxe_pkg

// ===== src/rxe_error_port.sv
// Error events, interrupt pins and audio serial output port of the receiver.
// Assumes event flags and sub-frames arrive on ref_clk; serial pins and strap are asynchronous.
`timescale 1ns/10ps

module rxe_error_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Control strap, high selects pin-strapped mode
  input wire logic pin_strap_mode,
  // Receiver events
  input wire logic unlock_flag,
  input wire logic parity_error_flag,
  input wire logic biphase_error,
  input wire logic frame_len_error,
  input wire logic validity_in,
  input wire logic non_audio_flag,
  input wire logic nonpcm_detect,
  input wire logic detect_a,
  input wire logic fs_change,
  input wire logic qcode_change,
  input wire logic chstat_change,
  input wire logic tape_category,
  input wire logic tape_start_id,
  // Received sub-frames
  input wire logic sf_valid,
  input wire logic sf_right,
  input wire logic [23:0] sf_word,
  // Serial audio pins
  input wire logic bclk_in,
  output logic bclk_out,
  output logic bclk_oe,
  input wire logic lrck_in,
  output logic lrck_out,
  output logic lrck_oe,
  input wire logic aux_audio_in,
  output logic serial_audio_out,
  // Status pins
  output logic validity_pin,
  output logic error_irq_pin,
  output logic stream_irq_pin,
  output logic rx_buffers_clear
);
  import rxe_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------------
  // Synchronisers for pins
  // ----------------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic bclk_s_d_q;
  logic strap_s;
  logic bclk_s;
  logic lrck_s;
  logic aux_s;

  // Two flops per pin; logic reads the second stage, and a third bit clock flop for edge detection
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      bclk_s_d_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {pin_strap_mode, bclk_in, lrck_in, aux_audio_in};
      sync2_q <= sync1_q;
      bclk_s_d_q <= sync2_q[2];
    end
  end

  assign strap_s = sync2_q[3];
  assign bclk_s = sync2_q[2];
  assign lrck_s = sync2_q[1];
  assign aux_s = sync2_q[0];

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [1:0] cm_q;
  logic [2:0] dif_q;
  logic [1:0] efh_q;
  logic [7:0] mask0_q;
  logic [7:0] mask1_q;
  logic [2:0] tape_ctl_q;
  logic qcode_change_flag_q;
  logic chstat_change_flag_q;
  logic tape_q;
  logic auto_flag;
  logic [7:0] stat0;
  logic rd_stat0;
  logic rd_stat1;

  // Control registers written by software
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cm_q <= CM_RST;
      dif_q <= DIF_RST;
      efh_q <= EFH_RST;
      mask0_q <= MASK_RST;
      mask1_q <= MASK_RST;
      tape_ctl_q <= TAPE_CTL_RST;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_CLK: cm_q <= reg_wdata[CM_LSB +: 2];
        ADDR_FMT: dif_q <= reg_wdata[DIF_LSB +: 3];
        ADDR_IOC1: efh_q <= reg_wdata[EFH_LSB +: 2];
        ADDR_MASK0: mask0_q <= reg_wdata;
        ADDR_MASK1: mask1_q <= reg_wdata;
        ADDR_TAPE: tape_ctl_q <= {reg_wdata[SUP_BIT], reg_wdata[MDAT1_BIT], reg_wdata[MDAT0_BIT]};
        default: ;
      endcase
    end
  end

  assign auto_flag = nonpcm_detect | detect_a;
  // Live bits pass straight through; only the change flags latch
  assign stat0 = {qcode_change_flag_q, auto_flag, chstat_change_flag_q, unlock_flag, validity_in, fs_change, non_audio_flag,
                  parity_error_flag};
  assign rd_stat0 = reg_rd && (reg_addr == ADDR_STAT0);
  assign rd_stat1 = reg_rd && (reg_addr == ADDR_STAT1);

  // Read data stands in the cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_CLK: reg_rdata <= {2'h0, cm_q, 4'h0};
        ADDR_FMT: reg_rdata <= {1'b0, dif_q, 4'h0};
        ADDR_IOC1: reg_rdata <= {efh_q, 6'h00};
        ADDR_MASK0: reg_rdata <= mask0_q;
        ADDR_MASK1: reg_rdata <= mask1_q;
        ADDR_TAPE: reg_rdata <= {3'h0, tape_ctl_q[2], 2'h0, tape_ctl_q[1:0]};
        ADDR_STAT0: reg_rdata <= stat0;
        ADDR_STAT1: reg_rdata <= {5'h00, tape_q, detect_a, nonpcm_detect};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Change flags: a new event in the read cycle survives the clear
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      qcode_change_flag_q <= 1'b0;
      chstat_change_flag_q <= 1'b0;
    end
    else
    begin
      qcode_change_flag_q <= qcode_change | (qcode_change_flag_q & ~rd_stat0);
      chstat_change_flag_q <= chstat_change | (chstat_change_flag_q & ~rd_stat0);
    end
  end

  // ----------------------------------------------------------------------
  // Serial port timing
  // ----------------------------------------------------------------------
  logic master;
  logic i2s;
  logic [3:0] div_q;
  logic fall_tick;
  logic rise_tick;
  logic [5:0] pos_q;
  logic half_q;
  logic [5:0] pos_nx;
  logic half_nx;
  logic slave_right;
  logic frame_start;

  assign master = (dif_q != FMT_SLV_LJ) && (dif_q != FMT_SLV_I2S);
  assign i2s = (dif_q == FMT_I2S) || (dif_q == FMT_SLV_I2S);
  assign slave_right = i2s ? lrck_s : ~lrck_s;

  // Bit clock divider; it keeps running in every format, but only master formats take frame time from it
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      div_q <= 4'h0;
      bclk_out <= 1'b1;
    end
    else if (div_q == BCLK_HALF_CYCLES - 4'h1)
    begin
      div_q <= 4'h0;
      bclk_out <= ~bclk_out;
    end
    else
      div_q <= div_q + 4'h1;
  end

  // Edges: own divider as master, synchronised partner clock as slave
  assign fall_tick = master ? ((div_q == BCLK_HALF_CYCLES - 4'h1) && bclk_out) : (bclk_s_d_q & ~bclk_s);
  assign rise_tick = master ? ((div_q == BCLK_HALF_CYCLES - 4'h1) && !bclk_out) : (~bclk_s_d_q & bclk_s);

  // Next bit position; a slave realigns on every frame clock change
  always_comb
  begin
    pos_nx = pos_q;
    half_nx = half_q;
    if (master)
    begin
      if (pos_q == SLOT_LAST_BIT)
      begin
        pos_nx = 6'h00;
        half_nx = ~half_q;
      end
      else
        pos_nx = pos_q + 6'h01;
    end
    else if (slave_right != half_q)
    begin
      pos_nx = 6'h00;
      half_nx = slave_right;
    end
    else if (pos_q != 6'h3F)
      pos_nx = pos_q + 6'h01;
  end

  assign frame_start = fall_tick && (pos_nx == 6'h00) && !half_nx;

  // Bit counter and frame clock, both moved on the falling bit clock edge
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pos_q <= SLOT_LAST_BIT;
      half_q <= 1'b1;
      lrck_out <= 1'b0;
    end
    else if (fall_tick)
    begin
      pos_q <= pos_nx;
      half_q <= half_nx;
      lrck_out <= i2s ? half_nx : ~half_nx;
    end
  end

  assign bclk_oe = master;
  assign lrck_oe = master;

  // ----------------------------------------------------------------------
  // Sample sources
  // ----------------------------------------------------------------------
  logic [23:0] held_q [2];
  logic [23:0] aux_word_q [2];
  logic [31:0] aux_sh_q;
  logic sf_err;
  logic aux_sel;
  logic [23:0] src_word;
  logic [31:0] slot_v;
  logic [31:0] shift_q;

  assign sf_err = parity_error_flag | biphase_error | frame_len_error;
  assign aux_sel = (cm_q == CM_PLL_OFF) || (cm_q == CM_AUX_ALWAYS) ||
                   ((cm_q == CM_AUX_UNLOCK) && unlock_flag);

  // Keep the last good sub-frame of each channel; errored ones are dropped
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      held_q[0] <= 24'h000000;
      held_q[1] <= 24'h000000;
    end
    else if (sf_valid && !sf_err && !unlock_flag)
      held_q[sf_right] <= sf_word;
  end

  // Aux input: shifted on rising edges, captured after bit 31 of each half
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      aux_sh_q <= 32'h00000000;
      aux_word_q[0] <= 24'h000000;
      aux_word_q[1] <= 24'h000000;
    end
    else
    begin
      if (rise_tick)
        aux_sh_q <= {aux_sh_q[30:0], aux_s};
      if (fall_tick && (pos_q == SLOT_LAST_BIT))
        aux_word_q[half_q] <= i2s ? aux_sh_q[30:7] : aux_sh_q[31:8];
    end
  end

  // Unlocked with no aux source, the port sends silence
  assign src_word = aux_sel ? aux_word_q[half_nx] : (unlock_flag ? 24'h000000 : held_q[half_nx]);

  // Place the word in a 32-bit slot; right-justified words are sign-extended
  always_comb
  begin
    unique case (dif_q)
      FMT_RJ16: slot_v = {{16{src_word[23]}}, src_word[23:8]};
      FMT_RJ18: slot_v = {{14{src_word[23]}}, src_word[23:6]};
      FMT_RJ20: slot_v = {{12{src_word[23]}}, src_word[23:4]};
      FMT_RJ24: slot_v = {{8{src_word[23]}}, src_word};
      FMT_LJ, FMT_SLV_LJ: slot_v = {src_word, 8'h00};
      FMT_I2S, FMT_SLV_I2S: slot_v = {1'b0, src_word, 7'h00};
    endcase
  end

  // Data moves on the falling edge, MSB first, so the partner samples on rising
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      shift_q <= 32'h00000000;
      serial_audio_out <= 1'b0;
    end
    else if (fall_tick)
    begin
      if (pos_nx == 6'h00)
      begin
        serial_audio_out <= slot_v[31];
        shift_q <= {slot_v[30:0], 1'b0};
      end
      else
      begin
        serial_audio_out <= shift_q[31];
        shift_q <= {shift_q[30:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Tape start flag
  // ----------------------------------------------------------------------
  logic tape_det;
  logic tape_raise;
  logic tape_seen_q;
  logic [11:0] gap_q;

  assign tape_det = tape_category & tape_start_id;
  assign tape_raise = tape_det && (!tape_ctl_q[2] || !tape_seen_q || (gap_q >= TAPE_GAP_FRAMES));

  // Frames since the last raised flag, saturating at the gap
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      gap_q <= 12'h000;
      tape_seen_q <= 1'b0;
    end
    else if (tape_raise)
    begin
      gap_q <= 12'h000;
      tape_seen_q <= 1'b1;
    end
    else if (frame_start && (gap_q < TAPE_GAP_FRAMES))
      gap_q <= gap_q + 12'h001;
  end

  // Sticky; reading the second status register clears it unless raised again
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      tape_q <= 1'b0;
    else
      tape_q <= tape_raise | (tape_q & ~rd_stat1);
  end

  // ----------------------------------------------------------------------
  // Interrupt pins and validity
  // ----------------------------------------------------------------------
  logic [8:0] ev9;
  logic raw0;
  logic raw1;
  logic pll_off;
  logic [12:0] hold_len;
  logic [12:0] hold_q;
  logic unlock_d_q;

  // Masks only gate the pins; status bits stay untouched
  assign ev9 = {tape_q, stat0};
  assign raw0 = strap_s ? (unlock_flag | parity_error_flag) :
                (|(ev9 & ~{tape_ctl_q[0], mask0_q}));
  assign raw1 = strap_s ? (auto_flag | non_audio_flag) :
                (|(ev9 & ~{tape_ctl_q[1], mask1_q}));
  assign pll_off = (cm_q == CM_PLL_OFF);

  // Strapped parts have no hold field, so they always use the 1024-frame figure
  always_comb
  begin
    unique case (strap_s ? 2'h1 : efh_q)
      2'h0: hold_len = HOLD_FRAMES_0;
      2'h1: hold_len = HOLD_FRAMES_1;
      2'h2: hold_len = HOLD_FRAMES_2;
      2'h3: hold_len = HOLD_FRAMES_3;
    endcase
  end

  // Countdown is reloaded while any event stands, so it restarts on each one
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      hold_q <= 13'h0000;
    else if (raw0)
      hold_q <= hold_len;
    else if (frame_start && (hold_q != 13'h0000))
      hold_q <= hold_q - 13'h0001;
  end

  // Pins are combinational so the stream pin drops in the clearing cycle
  assign error_irq_pin = !pll_off && (raw0 || (hold_q != 13'h0000));
  assign stream_irq_pin = !pll_off && raw1;

  // Validity forced low on unlock, and on parity errors when strapped; unlock clears the stored buffers once
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      validity_pin <= 1'b0;
      unlock_d_q <= 1'b0;
      rx_buffers_clear <= 1'b0;
    end
    else
    begin
      validity_pin <= (unlock_flag || (strap_s && parity_error_flag)) ? 1'b0 : validity_in;
      unlock_d_q <= unlock_flag;
      rx_buffers_clear <= unlock_flag & ~unlock_d_q;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  pll_off_low_a: assert property (pll_off |-> !error_irq_pin && !stream_irq_pin)
    else $error("interrupt pin high with recovery PLL off");
  strap_pins_a: assert property (strap_s && !pll_off |-> stream_irq_pin == (auto_flag | non_audio_flag)
    && (error_irq_pin || !(unlock_flag | parity_error_flag)))
    else $error("strapped interrupt pins wrong");
  err_hold_a: assert property (strap_s && !pll_off && $fell(raw0)
    |-> error_irq_pin && hold_q == HOLD_FRAMES_1)
    else $error("error pin did not hold after events cleared");
  hold_reload_a: assert property ($rose(raw0) |=> hold_q == $past(hold_len))
    else $error("hold countdown not restarted");
  stream_drop_a: assert property (!strap_s && !raw1 |-> !stream_irq_pin)
    else $error("stream pin held after events cleared");
  valid_force_a: assert property (strap_s && (unlock_flag | parity_error_flag) |=> !validity_pin)
    else $error("validity pin not forced low");
  auto_read_a: assert property (rd_stat0 |=> reg_rdata[6] == $past(auto_flag))
    else $error("auto status bit wrong");
  tape_keep_a: assert property (tape_q && !rd_stat1 |=> tape_q)
    else $error("tape start flag lost without a read");
  tape_supp_a: assert property (tape_ctl_q[2] && tape_seen_q && gap_q < TAPE_GAP_FRAMES && !tape_q
    && !rd_stat1 |=> !tape_q)
    else $error("tape start flag raised inside the gap");
  tape_set_a: assert property (tape_det && !tape_ctl_q[2] |=> tape_q)
    else $error("tape start flag not raised");
  held_keep_a: assert property (sf_valid && sf_err |=> $stable(held_q[0]) && $stable(held_q[1]))
    else $error("errored sub-frame stored");
  unlock_zero_a: assert property (fall_tick && pos_nx == 6'h00 && unlock_flag && !aux_sel
    |=> !serial_audio_out)
    else $error("unlocked output not zero");
  master_oe_a: assert property (dif_q < FMT_SLV_LJ |-> bclk_oe && lrck_oe)
    else $error("master format not driving clocks");

  hold_expire_c: cover property (!raw0 && hold_q == 13'h0001 && frame_start ##1 !error_irq_pin);
  tape_raise_c: cover property (tape_raise && tape_ctl_q[2] && tape_seen_q);
  aux_path_c: cover property (aux_sel && frame_start);
  slave_frame_c: cover property (!master && frame_start);

endmodule : rxe_error_port

// ===== tb/rxe_audio_peer.sv
// Model of the downstream audio processor on the serial port.
// Assumes the bench resolves the bit clock wire from both drivers.
`timescale 1ns/10ps

module rxe_audio_peer (
  // Control and the resolved bit clock
  input wire logic slave_en,
  input wire logic bclk_line,
  // Clocks and aux data toward the device
  output logic bclk_drv,
  output logic lrck_drv,
  output logic aux_data
);
  logic [5:0] bit_cnt = 6'h00;

  // 320 ns bit clock, standing still while the device is master
  initial
  begin
    aux_data = 1'b0;
    bclk_drv = 1'b1;
    forever
    begin
      #160;
      if (slave_en)
        bclk_drv = ~bclk_drv;
    end
  end

  // Change on falling edges so the device samples settled bits
  always @(negedge bclk_line)
  begin
    bit_cnt <= bit_cnt + 6'h01;
    aux_data <= bit_cnt[0] ^ bit_cnt[3];
  end

  assign lrck_drv = ~bit_cnt[5]; // Left half high, 32 bits each
endmodule : rxe_audio_peer

// ===== tb/rxe_error_port_tb.sv
// Self-checking bench for the error, interrupt and serial port block.
// Assumes a 25 MHz ref_clk and the peer model on the serial pins.
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module rxe_error_port_tb;
  import rxe_pkg::*;
  typedef struct packed {logic [5:0] ev; logic [7:0] s0; logic irq;} rxe_row_t;
  logic ref_clk, reset, reg_wr, reg_rd, pin_strap_mode, slave_en, sf_valid, sf_right;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val, sf_div;
  logic unlock_flag, parity_error_flag, biphase_error, frame_len_error, validity_in, non_audio_flag;
  logic nonpcm_detect, detect_a, fs_change, qcode_change, chstat_change, tape_category, tape_start_id;
  logic [23:0] sf_word, got;
  logic bclk_out, bclk_oe, lrck_out, lrck_oe, serial_audio_out, validity_pin;
  logic error_irq_pin, stream_irq_pin, rx_buffers_clear, bclk_drv, lrck_drv, aux_data;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  // Rows: {unlock, parity, nonpcm, detect_a, non_audio, fs change}, status 0, stream pin
  rxe_row_t rows [8] = '{'{6'h00, 8'h00, 1'b0}, '{6'h20, 8'h10, 1'b1}, '{6'h10, 8'h01, 1'b1},
    '{6'h08, 8'h40, 1'b1}, '{6'h04, 8'h40, 1'b1}, '{6'h02, 8'h02, 1'b1}, '{6'h01, 8'h04, 1'b1},
    '{6'h00, 8'h00, 1'b0}};
  wire bclk_line = bclk_oe ? bclk_out : bclk_drv; // Whoever enables drives the wire
  wire lrck_line = lrck_oe ? lrck_out : lrck_drv;

  rxe_error_port uut (.*, .bclk_in(bclk_line), .lrck_in(lrck_line), .aux_audio_in(aux_data));
  rxe_audio_peer peer (.*);

  // 40 ns clock
  initial
  begin
    ref_clk = 1'b0;
    forever
      #20 ref_clk = ~ref_clk;
  end

  // Sub-frame strobes faster than frames, so every half sees fresh data
  always @(posedge ref_clk)
  begin
    sf_div <= sf_div + 8'h01;
    sf_valid <= (sf_div == 8'h00);
    if (sf_div == 8'h00)
      sf_right <= ~sf_right;
  end

  // Hang guard, several times the expected run
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    @(posedge ref_clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle

  // Strap sync needs a few edges after release
  task automatic rst();
    @(posedge ref_clk) reset <= 1'b1;
    {unlock_flag, nonpcm_detect, non_audio_flag, fs_change, pin_strap_mode, validity_in} <= '0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : rst

  // Second whole word taken, as the first may predate the setup
  task automatic cap();
    repeat (2)
    begin
      @(posedge lrck_line);
      repeat (24) @(posedge bclk_line) got = {got[22:0], serial_audio_out};
    end
  endtask : cap

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial
  begin
    reset = 1'b1;
    {reg_wr, reg_rd, pin_strap_mode, slave_en, reg_addr, reg_wdata, unlock_flag, parity_error_flag} = '0;
    {biphase_error, frame_len_error, validity_in, non_audio_flag, nonpcm_detect, detect_a} = '0;
    {fs_change, qcode_change, chstat_change, tape_category, tape_start_id, sf_right, sf_word, sf_div} = '0;
    rst();
    rd(ADDR_FMT);
    `CHK(rd_val, {1'b0, DIF_RST, 4'h0})
    `CHK(bclk_oe, 1'b1)
    rd(ADDR_IOC1);
    `CHK(rd_val, {EFH_RST, 6'h00})
    rd(5'h1F);
    `CHK(rd_val, 8'h00)
    foreach (rows[i])
    begin
      @(posedge ref_clk) {unlock_flag, parity_error_flag, nonpcm_detect, detect_a, non_audio_flag, fs_change} <= rows[i].ev;
      settle();
      `CHK(stream_irq_pin, rows[i].irq)
      rd(ADDR_STAT0);
      `CHK(rd_val, rows[i].s0)
    end
    @(posedge ref_clk) {qcode_change, chstat_change} <= 2'b11;
    @(posedge ref_clk) {qcode_change, chstat_change} <= 2'b00;
    rd(ADDR_STAT0);
    `CHK(rd_val, 8'hA0)
    rd(ADDR_STAT0);
    `CHK(rd_val, 8'h00)
    for (int k = 0; k < 4; k++)
    begin
      if (k == 3)
        wr(ADDR_TAPE, 8'h10);
      @(posedge ref_clk) {tape_category, tape_start_id} <= {k != 0, 1'b1};
      @(posedge ref_clk) tape_start_id <= 1'b0;
      rd(ADDR_STAT1);
      `CHK(rd_val, {5'h00, k == 1 || k == 2, 2'b00})
    end
    wr(ADDR_MASK1, 8'h10);
    @(posedge ref_clk) unlock_flag <= 1'b1;
    settle();
    `CHK({error_irq_pin, stream_irq_pin}, 2'b10)
    rd(ADDR_STAT0);
    `CHK(rd_val, 8'h10)
    @(posedge ref_clk) nonpcm_detect <= 1'b1;
    settle();
    `CHK(stream_irq_pin, 1'b1)
    @(posedge ref_clk) nonpcm_detect <= 1'b0;
    #1 `CHK(stream_irq_pin, 1'b0)
    wr(ADDR_CLK, {2'b00, CM_PLL_OFF, 4'h0});
    @(posedge ref_clk) nonpcm_detect <= 1'b1;
    settle();
    `CHK({error_irq_pin, stream_irq_pin}, 2'b00)
    rst();
    @(posedge ref_clk) pin_strap_mode <= 1'b1;
    settle();
    @(posedge ref_clk) {validity_in, fs_change} <= 2'b11;
    settle();
    `CHK({error_irq_pin, stream_irq_pin}, 2'b00)
    @(posedge ref_clk) unlock_flag <= 1'b1;
    @(posedge ref_clk) #1 `CHK(rx_buffers_clear, 1'b1)
    settle();
    `CHK({error_irq_pin, stream_irq_pin, validity_pin}, 3'b100)
    @(posedge ref_clk) {unlock_flag, non_audio_flag} <= 2'b01;
    settle();
    `CHK({error_irq_pin, stream_irq_pin}, 2'b11)
    rst();
    @(posedge ref_clk) sf_word <= 24'h9A5C36;
    wr(ADDR_FMT, {1'b0, FMT_LJ, 4'h0});
    cap();
    `CHK(got, 24'h9A5C36)
    wr(ADDR_FMT, {1'b0, FMT_RJ16, 4'h0});
    cap();
    `CHK(got, 24'hFFFF9A)
    wr(ADDR_FMT, {1'b0, FMT_I2S, 4'h0});
    cap();
    `CHK(got, 24'h4D2E1B)
    @(posedge ref_clk) unlock_flag <= 1'b1;
    cap();
    `CHK(got, 24'h000000)
    @(posedge ref_clk) {unlock_flag, slave_en} <= 2'b01;
    wr(ADDR_FMT, {1'b0, FMT_SLV_LJ, 4'h0});
    #1 `CHK(bclk_oe, 1'b0)
    cap();
    `CHK(got, 24'h9A5C36)
    end_of_test();
  end
endmodule : rxe_error_port_tb
